// ==== inc/mbox_pkg.sv ====
// Package: address map, field layout and types of the mailbox unit
//------------------------------------------------------------------
//------------------------------------------------------------------
`default_nettype none

package mbox_pkg;

  //------------------------------------------------------------------
  // Address map, region in paddr[6:4], box or misc in paddr[3:2]
  //------------------------------------------------------------------
  localparam logic [2:0] R_PCI_OUT  = 3'h0;
  localparam logic [2:0] R_PCI_IN   = 3'h1;
  localparam logic [2:0] R_PCI_MISC = 3'h2;
  localparam logic [2:0] R_LOC_OUT  = 3'h4;
  localparam logic [2:0] R_LOC_IN   = 3'h5;
  localparam logic [2:0] R_LOC_MISC = 3'h6;
  localparam logic [1:0] M_FLAGS    = 2'h0;
  localparam logic [1:0] M_CTL      = 2'h1;
  localparam logic [1:0] M_IRQ      = 2'h2;

  //------------------------------------------------------------------
  // Field layout
  //------------------------------------------------------------------
  localparam int unsigned FLAG_RST_BIT = 27;
  localparam int unsigned SEL_LO       = 0;
  localparam int unsigned SEL_HI       = 8;
  localparam int unsigned IND_LO       = 16;
  localparam int unsigned IND_HI       = 17;
  localparam logic [3:0]  EXT_IDX      = 4'hF;
  localparam logic [15:0] EXT_FLAG     = 16'h8000;
  localparam logic [15:0] LANES_ALL    = 16'h000F;
  localparam logic [31:0] ZERO_WORD    = 32'h0000_0000;

  typedef struct packed {
    logic       en;
    logic [1:0] box;
    logic [1:0] lane;
  } irq_sel_s;

  localparam irq_sel_s SEL_RST = 5'h00;

endpackage

`default_nettype wire

// ==== hdl/mbox_unit.sv ====
// Bidirectional mailbox unit with APB register access
`timescale 1ns/1ps
`default_nettype none

module mbox_unit (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // External mailbox pins and boot strap
  input  wire logic [7:0]  ext_box_data_in,
  input  wire logic        ext_box_load_strobe,
  input  wire logic        byte_wide_boot,
  // Interrupts
  output logic             inta_n,
  output logic             local_irq_n
);

  //------------------------------------------------------------------
  // Helpers
  //------------------------------------------------------------------
  function automatic logic sel_hit(mbox_pkg::irq_sel_s s,
                                   logic [15:0] v);
    sel_hit = s.en & v[{s.box, s.lane}];
  endfunction

  function automatic logic [31:0] irq_img(mbox_pkg::irq_sel_s lo,
                                          mbox_pkg::irq_sel_s hi,
                                          logic il, logic ih);
    irq_img = mbox_pkg::ZERO_WORD;
    irq_img[mbox_pkg::SEL_LO +: 5] = lo;
    irq_img[mbox_pkg::SEL_HI +: 5] = hi;
    irq_img[mbox_pkg::IND_LO] = il;
    irq_img[mbox_pkg::IND_HI] = ih;
  endfunction

  //------------------------------------------------------------------
  // Declarations
  //------------------------------------------------------------------
  logic [7:0]          p2a [16];
  logic [7:0]          a2p [16];
  logic [127:0]        p2a_v, a2p_v;
  logic [15:0]         p2a_full, a2p_full;
  logic [15:0]         p2a_we, a2p_we;
  logic [15:0]         p2a_rd, a2p_rd;
  logic [15:0]         a2p_set, ext_set;
  mbox_pkg::irq_sel_s  pci_out_sel, pci_in_sel, loc_in_sel, loc_out_sel;
  logic                pci_out_pend, pci_in_pend, loc_in_pend, loc_out_pend;
  logic                access, done, wr_done, rd_done, mapped;
  logic [2:0]          region;
  logic [1:0]          box;
  logic [31:0]         next_rdata;
  logic                pci_irq_wr, loc_irq_wr, flag_rst;
  logic                pci_out_clr, pci_in_clr, loc_in_clr, loc_out_clr;
  logic                pci_out_ev, pci_in_ev, loc_in_ev, loc_out_ev;
  logic                stb_s1, stb_s2, stb_s3, ext_rise;
  logic [7:0]          dat_s1, dat_s2;
  logic                wide_s1, wide_s2;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  //------------------------------------------------------------------
  // APB decode
  //------------------------------------------------------------------
  // Every transfer is a single data phase; no burst exists on APB
  assign access  = psel & penable & ~pready;
  assign done    = psel & penable & pready;
  assign wr_done = done & pwrite;
  assign rd_done = done & ~pwrite;
  assign region  = paddr[6:4];
  assign box     = paddr[3:2];

  // Misc regions hold three registers; every other gap is unmapped
  assign mapped = paddr[31:7] == 25'h0000000 && paddr[1:0] == 2'h0
                  && (region inside {mbox_pkg::R_PCI_OUT, mbox_pkg::R_PCI_IN,
                                     mbox_pkg::R_LOC_OUT, mbox_pkg::R_LOC_IN}
                      || (region inside {mbox_pkg::R_PCI_MISC,
                                         mbox_pkg::R_LOC_MISC}
                          && box != 2'h3));

  // Byte strobes pick bytes and flags
  always_comb
  begin
    p2a_we = '0;
    a2p_we = '0;
    p2a_rd = '0;
    a2p_rd = '0;
    if (wr_done && mapped && region == mbox_pkg::R_PCI_OUT)
      p2a_we = 16'(pstrb) << {box, 2'h0};
    if (wr_done && mapped && region == mbox_pkg::R_LOC_OUT)
      a2p_we = 16'(pstrb) << {box, 2'h0};
    // Reads carry no strobes, so a read empties the whole word
    if (rd_done && mapped && region == mbox_pkg::R_PCI_IN)
      a2p_rd = mbox_pkg::LANES_ALL << {box, 2'h0};
    if (rd_done && mapped && region == mbox_pkg::R_LOC_IN)
      p2a_rd = mbox_pkg::LANES_ALL << {box, 2'h0};
  end

  // Unmapped aliases must not reach the control bits
  assign pci_irq_wr = wr_done && region == mbox_pkg::R_PCI_MISC
                      && box == mbox_pkg::M_IRQ && mapped;
  assign loc_irq_wr = wr_done && region == mbox_pkg::R_LOC_MISC
                      && box == mbox_pkg::M_IRQ && mapped;
  // Either side may reset all flags; zero does nothing
  assign flag_rst = wr_done && mapped && box == mbox_pkg::M_CTL && pstrb[3]
                    && pwdata[mbox_pkg::FLAG_RST_BIT]
                    && (region == mbox_pkg::R_PCI_MISC
                        || region == mbox_pkg::R_LOC_MISC);
  assign pci_out_clr = pci_irq_wr && pstrb[2] && pwdata[mbox_pkg::IND_LO];
  assign pci_in_clr  = pci_irq_wr && pstrb[2] && pwdata[mbox_pkg::IND_HI];
  assign loc_in_clr  = loc_irq_wr && pstrb[2] && pwdata[mbox_pkg::IND_LO];
  assign loc_out_clr = loc_irq_wr && pstrb[2] && pwdata[mbox_pkg::IND_HI];

  //------------------------------------------------------------------
  // External load path
  //------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      {stb_s3, stb_s2, stb_s1} <= 3'h7;
      {dat_s2, dat_s1}         <= 16'h0000;
      {wide_s2, wide_s1}       <= 2'h0;
    end
    else
    begin
      {stb_s3, stb_s2, stb_s1} <= {stb_s2, stb_s1, ext_box_load_strobe};
      {dat_s2, dat_s1}         <= {dat_s1, ext_box_data_in};
      {wide_s2, wide_s1}       <= {wide_s1, byte_wide_boot};
    end
  end

  // Idle-high strobe, low-then-high pulse is a request
  assign ext_rise = stb_s2 & ~stb_s3;
  // Pins feed box 4 byte 3 only without byte-wide boot
  // Ignored until the pci irq is cleared and released
  assign ext_set = (ext_rise && !wide_s2 && !pci_in_pend && inta_n)
                   ? mbox_pkg::EXT_FLAG : '0;
  assign a2p_set = a2p_we | ext_set;

  //------------------------------------------------------------------
  // Mailbox storage
  //------------------------------------------------------------------
  for (genvar g = 0; g < 16; g++)
  begin : g_byte
    // Full bytes are simply overwritten
    always_ff @(posedge clk)
    begin
      if (!rst_n)
      begin
        p2a[g] <= 8'h00;
        a2p[g] <= 8'h00;
      end
      else
      begin
        if (p2a_we[g])
          p2a[g] <= pwdata[8*(g%4) +: 8];
        if (a2p_we[g])
          a2p[g] <= pwdata[8*(g%4) +: 8];
        else if (ext_set[g])
          a2p[g] <= dat_s2;
      end
    end
    assign p2a_v[8*g +: 8] = p2a[g];
    assign a2p_v[8*g +: 8] = a2p[g];
  end

  //------------------------------------------------------------------
  // Flags
  //------------------------------------------------------------------
  // Set wins over any clear in the same cycle
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      p2a_full <= '0;
      a2p_full <= '0;
    end
    else
    begin
      p2a_full <= (flag_rst ? '0 : (p2a_full & ~p2a_rd)) | p2a_we;
      a2p_full <= (flag_rst ? '0 : (a2p_full & ~a2p_rd)) | a2p_set;
    end
  end

  //------------------------------------------------------------------
  // Interrupt configuration and pending bits
  //------------------------------------------------------------------
  // Each side keeps its own selectors
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pci_out_sel <= mbox_pkg::SEL_RST;
      pci_in_sel  <= mbox_pkg::SEL_RST;
      loc_in_sel  <= mbox_pkg::SEL_RST;
      loc_out_sel <= mbox_pkg::SEL_RST;
    end
    else
    begin
      if (pci_irq_wr && pstrb[0])
        pci_out_sel <= pwdata[mbox_pkg::SEL_LO +: 5];
      if (pci_irq_wr && pstrb[1])
        pci_in_sel <= pwdata[mbox_pkg::SEL_HI +: 5];
      if (loc_irq_wr && pstrb[0])
        loc_in_sel <= pwdata[mbox_pkg::SEL_LO +: 5];
      if (loc_irq_wr && pstrb[1])
        loc_out_sel <= pwdata[mbox_pkg::SEL_HI +: 5];
    end
  end

  // Full on write, empty only when a full byte is read
  assign pci_in_ev  = sel_hit(pci_in_sel, a2p_set);
  assign pci_out_ev = sel_hit(pci_out_sel, p2a_rd & p2a_full);
  assign loc_in_ev  = sel_hit(loc_in_sel, p2a_we);
  assign loc_out_ev = sel_hit(loc_out_sel, a2p_rd & a2p_full);

  // Pending until software writes one; event wins
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pci_out_pend <= 1'b0;
      pci_in_pend  <= 1'b0;
      loc_in_pend  <= 1'b0;
      loc_out_pend <= 1'b0;
    end
    else
    begin
      pci_out_pend <= pci_out_ev | (pci_out_pend & ~pci_out_clr);
      pci_in_pend  <= pci_in_ev | (pci_in_pend & ~pci_in_clr);
      loc_in_pend  <= loc_in_ev | (loc_in_pend & ~loc_in_clr);
      loc_out_pend <= loc_out_ev | (loc_out_pend & ~loc_out_clr);
    end
  end

  // One edge after the pending bit, both ways
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      inta_n <= 1'b1;
    else
      inta_n <= ~(pci_in_pend | pci_out_pend);
  end

  // Set lags by one clock, clear acts at the clearing edge
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      local_irq_n <= 1'b1;
    else
      local_irq_n <= ~((loc_in_pend & ~loc_in_clr)
                       | (loc_out_pend & ~loc_out_clr));
  end

  //------------------------------------------------------------------
  // Read data and APB answer
  //------------------------------------------------------------------
  always_comb
  begin
    next_rdata = mbox_pkg::ZERO_WORD;
    case (region)
      mbox_pkg::R_PCI_OUT: next_rdata = p2a_v[{box, 5'h00} +: 32];
      mbox_pkg::R_PCI_IN:
      begin
        next_rdata = a2p_v[{box, 5'h00} +: 32];
        if (wide_s2 && {box, 2'h3} == mbox_pkg::EXT_IDX)
          next_rdata[31:24] = 8'h00;
      end
      mbox_pkg::R_LOC_OUT: next_rdata = a2p_v[{box, 5'h00} +: 32];
      mbox_pkg::R_LOC_IN:  next_rdata = p2a_v[{box, 5'h00} +: 32];
      mbox_pkg::R_PCI_MISC,
      mbox_pkg::R_LOC_MISC:
      begin
        // Same layout both sides; reset bit reads zero
        if (box == mbox_pkg::M_FLAGS)
          next_rdata = {a2p_full, p2a_full};
        else if (box == mbox_pkg::M_IRQ && region == mbox_pkg::R_PCI_MISC)
          next_rdata = irq_img(pci_out_sel, pci_in_sel,
                               pci_out_pend, pci_in_pend);
        else if (box == mbox_pkg::M_IRQ)
          next_rdata = irq_img(loc_in_sel, loc_out_sel,
                               loc_in_pend, loc_out_pend);
      end
      default: next_rdata = mbox_pkg::ZERO_WORD;
    endcase
  end

  // Slave only: answers a fixed two-cycle access
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pready  <= 1'b0;
      prdata  <= mbox_pkg::ZERO_WORD;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= access;
      pslverr <= access & ~mapped;
      if (access && !pwrite)
        prdata <= mapped ? next_rdata : mbox_pkg::ZERO_WORD;
    end
  end

  //------------------------------------------------------------------
  // Assertions
  //------------------------------------------------------------------
  sequence s_no_set;
    (p2a_we == '0) && (a2p_set == '0);
  endsequence
  sequence s_flags_wr;
    wr_done && box == mbox_pkg::M_FLAGS
      && (region == mbox_pkg::R_PCI_MISC || region == mbox_pkg::R_LOC_MISC);
  endsequence

  AST_FLAGS_RO: assert property (
    s_flags_wr and s_no_set |=> $stable({a2p_full, p2a_full}))
    else $error("flag register changed by a write");
  AST_FLAG_RST: assert property (
    flag_rst and s_no_set |=> {a2p_full, p2a_full} == 32'h0000_0000)
    else $error("flag reset left flags set");
  AST_SET_FLAG: assert property (
    p2a_we != '0 |=> (p2a_full & $past(p2a_we)) == $past(p2a_we))
    else $error("written byte flag not set");
  AST_RD_CLR: assert property (
    (a2p_rd != '0) and (a2p_set == '0) |=> (a2p_full & $past(a2p_rd)) == '0)
    else $error("read did not clear flags");
  AST_INTA_SET: assert property (
    pci_in_ev |-> ##2 !inta_n)
    else $error("pci irq not asserted in time");
  AST_INTA_REL: assert property (
    (pci_in_clr || !pci_in_pend) && (pci_out_clr || !pci_out_pend)
      && (pci_in_pend || pci_out_pend) && !pci_in_ev && !pci_out_ev
      |-> ##1 !inta_n ##1 inta_n)
    else $error("pci irq release timing wrong");
  AST_LIRQ_SET: assert property (
    loc_in_ev && !loc_in_pend && !loc_out_pend ##1 !loc_in_clr
      |-> local_irq_n ##1 !local_irq_n)
    else $error("local irq not one clock late");
  AST_LIRQ_REL: assert property (
    (loc_in_clr || !loc_in_pend) && (loc_out_clr || !loc_out_pend)
      && (loc_in_pend || loc_out_pend) && !loc_in_ev && !loc_out_ev
      |=> local_irq_n)
    else $error("local irq not released at once");
  AST_EXT_HOLD: assert property (
    ext_rise && !inta_n && !a2p_we[15] |=> $stable(a2p[15]))
    else $error("strobe taken while irq pending");
  AST_WIDE_ZERO: assert property (
    access && !pwrite && wide_s2 && mapped && region == mbox_pkg::R_PCI_IN
      && box == 2'h3 |=> prdata[31:24] == 8'h00)
    else $error("box 4 byte 3 not zero");

endmodule

`default_nettype wire

// ==== testbench/ext_pin_model.sv ====
// Partner model: local-side logic driving the external mailbox pins
`timescale 1ns/1ps
`default_nettype none

module ext_pin_model (
  // Clock
  input  wire logic       clk,
  // External mailbox pins
  output logic [7:0]      ext_box_data_in,
  output logic            ext_box_load_strobe
);
  initial
  begin
    ext_box_load_strobe = 1'b1;
    ext_box_data_in     = 8'h5A;
  end

  // Low then high; slow stretches the low phase
  task automatic pulse(input logic [7:0] d, input int slow);
    begin
      @(posedge clk);
      ext_box_load_strobe <= 1'b0;
      ext_box_data_in     <= d;
      repeat (2 + slow) @(posedge clk);
      ext_box_load_strobe <= 1'b1;
      // Data outlives the two-stage sync, then goes stale
      repeat (4) @(posedge clk);
      ext_box_data_in <= ~d;
    end
  endtask
endmodule

`default_nettype wire

// ==== testbench/pci_local_mailbox_tb_top.sv ====
// Self-checking testbench of the mailbox unit
`timescale 1ns/1ps
`default_nettype none

module pci_local_mailbox_tb_top;
  logic        clk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic [7:0]  ext_data;
  logic        ext_strobe;
  logic        byte_wide_boot;
  logic        inta_n;
  logic        local_irq_n;
  logic [32:0] exp_q[$];
  logic [31:0] seed;
  logic [31:0] f;
  logic [31:0] g;
  logic [2:0]  r;
  int          fails;
  int          check_count;

  mbox_unit mbox_unit_inst (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .ext_box_data_in(ext_data), .ext_box_load_strobe(ext_strobe),
    .byte_wide_boot(byte_wide_boot), .inta_n(inta_n),
    .local_irq_n(local_irq_n)
  );

  ext_pin_model ext_pin_model_inst (
    .clk(clk), .ext_box_data_in(ext_data), .ext_box_load_strobe(ext_strobe)
  );

  always #25 clk = ~clk;

  //------------------------------------------------------------------
  // Helpers
  //------------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [31:0] adr(input logic [2:0] rg,
                                      input logic [1:0] i);
    return {25'h0, rg, i, 2'b00};
  endfunction

  function automatic logic pick(input bit pci);
    return pci ? inta_n : local_irq_n;
  endfunction

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks=%0d fails=%0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // One idle cycle ahead keeps each strobe to one change per step
  task automatic apb(input logic w, input logic [31:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    begin
      @(posedge clk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      pstrb   <= s;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      // Only the watchdog ends a wait for the answer
      while (pready !== 1'b1)
        @(posedge clk);
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    apb(1'b1, a, d, s);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    exp_q.push_back({1'b0, e});
    apb(1'b0, a, 32'h0, 4'h0);
  endtask

  // Output must not move yet, then move on the next edge
  task automatic late(input bit pci, input logic lvl);
    #1 chk({32'h0, pick(pci)}, {32'h0, ~lvl});
    @(posedge clk);
    #1 chk({32'h0, pick(pci)}, {32'h0, lvl});
  endtask

  task automatic wait_inta(input logic lvl);
    int n;
    begin
      n = 0;
      while (inta_n !== lvl && n < 20)
      begin
        @(posedge clk);
        n++;
      end
      #1 chk({32'h0, inta_n}, {32'h0, lvl});
    end
  endtask

  // Arm a selector on box 1 lane 0, trigger, hold, clear, disarm
  task automatic irq_case(input logic [2:0] cr, input logic [31:0] cw,
                          input logic [2:0] wr_r, input bit do_rd,
                          input bit pci, input logic [31:0] kw);
    logic [31:0] v;
    begin
      v = rnd();
      wr(adr(cr, mbox_pkg::M_IRQ), cw, 4'b0011);
      wr(adr(wr_r, 2'h0), v, 4'b0001);
      // Out region 0 and 4 pair with in region 5 and 1
      if (do_rd)
        rd(adr(wr_r ^ 3'h5, 2'h0), {24'h0, v[7:0]});
      late(pci, 1'b0);
      chk({32'h0, pick(!pci)}, 33'h1);
      repeat (4) @(posedge clk);
      #1 chk({32'h0, pick(pci)}, 33'h0);
      wr(adr(cr, mbox_pkg::M_IRQ), kw, 4'b0100);
      if (pci)
        late(1'b1, 1'b1);
      else
        #1 chk({32'h0, local_irq_n}, 33'h1);
      wr(adr(cr, mbox_pkg::M_IRQ), 32'h0, 4'b0011);
    end
  endtask

  // Read results against the oldest note
  always @(posedge clk)
  begin
    if (psel && penable && pready === 1'b1 && !pwrite)
    begin
      if (exp_q.size() == 0)
      begin
        fails++;
        $display("[FAIL] t=%0t got=%h exp=none", $time, prdata);
      end
      else
        chk({pslverr, prdata}, exp_q.pop_front());
    end
  end

  // Whole run is well under a thousand cycles
  initial
  begin
    #(50 * 40000);
    fails++;
    finish_test();
  end

  //------------------------------------------------------------------
  // Main sequence
  //------------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    pstrb = 4'h0;
    byte_wide_boot = 1'b0;
    seed = 32'hDF53;
    fails = 0;
    check_count = 0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1 chk({31'h0, inta_n, local_irq_n}, 33'h3);
    rd(adr(mbox_pkg::R_PCI_MISC, mbox_pkg::M_FLAGS), 32'h0);
    f = rnd();
    g = rnd();
    wr(adr(mbox_pkg::R_PCI_OUT, 2'h1), f, 4'b0011);
    wr(adr(mbox_pkg::R_PCI_OUT, 2'h1), g, 4'b0001);
    rd(adr(mbox_pkg::R_PCI_MISC, mbox_pkg::M_FLAGS), 32'h30);
    wr(adr(mbox_pkg::R_LOC_MISC, mbox_pkg::M_FLAGS), 32'h0, 4'hF);
    wr(adr(mbox_pkg::R_PCI_MISC, mbox_pkg::M_FLAGS), '1, 4'hF);
    rd(adr(mbox_pkg::R_LOC_MISC, mbox_pkg::M_FLAGS), 32'h30);
    rd(adr(mbox_pkg::R_LOC_IN, 2'h1), {16'h0, f[15:8], g[7:0]});
    rd(adr(mbox_pkg::R_PCI_MISC, mbox_pkg::M_FLAGS), 32'h0);
    rd(adr(mbox_pkg::R_LOC_IN, 2'h1), {16'h0, f[15:8], g[7:0]});
    f = rnd();
    for (int i = 0; i < 2; i++)
    begin
      r = i ? mbox_pkg::R_LOC_MISC : mbox_pkg::R_PCI_MISC;
      wr(adr(mbox_pkg::R_LOC_OUT, 2'h3), f, 4'hF);
      wr(adr(r, mbox_pkg::M_CTL), 32'h0, 4'hF);
      rd(adr(mbox_pkg::R_PCI_MISC, mbox_pkg::M_FLAGS), 32'hF000_0000);
      wr(adr(r, mbox_pkg::M_CTL), 32'h1 << 27, 4'b1000);
      rd(adr(mbox_pkg::R_LOC_MISC, mbox_pkg::M_FLAGS), 32'h0);
    end
    irq_case(mbox_pkg::R_PCI_MISC, 32'h1000, mbox_pkg::R_LOC_OUT, 1'b0,
             1'b1, 32'h2_0000);
    irq_case(mbox_pkg::R_PCI_MISC, 32'h0010, mbox_pkg::R_PCI_OUT, 1'b1,
             1'b1, 32'h1_0000);
    irq_case(mbox_pkg::R_LOC_MISC, 32'h0010, mbox_pkg::R_PCI_OUT, 1'b0,
             1'b0, 32'h1_0000);
    irq_case(mbox_pkg::R_LOC_MISC, 32'h1000, mbox_pkg::R_LOC_OUT, 1'b1,
             1'b0, 32'h2_0000);
    wr(adr(mbox_pkg::R_PCI_MISC, mbox_pkg::M_CTL), 32'h1 << 27, 4'b1000);
    wr(adr(mbox_pkg::R_PCI_MISC, mbox_pkg::M_IRQ), 32'h1F00, 4'b0011);
    g = rnd();
    ext_pin_model_inst.pulse(g[7:0], 0);
    wait_inta(1'b0);
    rd(adr(mbox_pkg::R_PCI_MISC, mbox_pkg::M_FLAGS), 32'h8000_0000);
    ext_pin_model_inst.pulse(~g[7:0], 3);
    repeat (4) @(posedge clk);
    rd(adr(mbox_pkg::R_PCI_IN, 2'h3), {g[7:0], f[23:0]});
    wr(adr(mbox_pkg::R_PCI_MISC, mbox_pkg::M_IRQ), 32'h2_0000, 4'b0100);
    late(1'b1, 1'b1);
    ext_pin_model_inst.pulse(8'h3C, 1);
    wait_inta(1'b0);
    wr(adr(mbox_pkg::R_PCI_MISC, mbox_pkg::M_IRQ), 32'h2_0000, 4'b0100);
    late(1'b1, 1'b1);
    @(posedge clk);
    byte_wide_boot <= 1'b1;
    repeat (3) @(posedge clk);
    rd(adr(mbox_pkg::R_PCI_IN, 2'h3), {8'h00, f[23:0]});
    ext_pin_model_inst.pulse(8'hC3, 0);
    repeat (6) @(posedge clk);
    #1 chk({32'h0, inta_n}, 33'h1);
    // Narrow master: one lane per access, lanes in turn
    for (int i = 0; i < 4; i++)
      wr(adr(mbox_pkg::R_LOC_OUT, 2'h2), f, 4'h1 << i);
    rd(adr(mbox_pkg::R_PCI_IN, 2'h2), f);
    // Unmapped region answers with an error and zero data
    exp_q.push_back({1'b1, 32'h0});
    apb(1'b0, 32'h0000_0030, 32'h0, 4'h0);
    repeat (2) @(posedge clk);
    finish_test();
  end
endmodule

`default_nettype wire
